// ==== ecr_assertions.sv ====
// Link checker watching the host and device ends
`timescale 1ns/1ps
module ecr_assertions
    import ecr_pkg::*;
#(
    parameter int PHY_WAIT_CYC = ECR_PHY_WAIT_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req,
    input wire logic we,
    input wire logic [1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic ack,
    input wire logic sys_cmd,
    input wire logic reset_pin_n
);
    logic [15:0] since_r;
    logic [7:0] hold_r;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Cycles left of a commanded system reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold_r <= 8'h00;
        end else if (sys_cmd) begin
            hold_r <= 8'(ECR_SYS_CMD_CYC);
        end else if (hold_r != 8'h00) begin
            hold_r <= hold_r - 8'h01;
        end
    end
    // Cycles since the pin was low or a reset command ended
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            since_r <= 16'hffff;
        end else if (!reset_pin_n || sys_cmd || hold_r != 8'h00) begin
            since_r <= 16'h0;
        end else if (since_r != 16'hffff) begin
            since_r <= since_r + 16'h1;
        end
    end
    property p_ack_follows;
        req && !ack |=> ack;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("ack late");
    property p_ack_pulse;
        ack |=> !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause;
        ack |-> $past(req) && !$past(ack);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    property p_req_hold;
        req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request moved");
    property p_phy_reserved;
        ack && !we && addr == ECR_IDX_PHY_CTL |-> (rdata & 16'h36ff) == 16'h0;
    endproperty
    a_phy_reserved: assert property (p_phy_reserved) else $error("reserved set");
    property p_unmapped_zero;
        ack && !we && addr == 2'h3 |-> rdata == 16'h0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("index 3 nonzero");
    property p_phy_wait;
        req && addr == ECR_IDX_PHY_CTL |-> since_r >= PHY_WAIT_CYC;
    endproperty
    a_phy_wait: assert property (p_phy_wait) else $error("PHY access early");
    property p_cmd_pulse;
        sys_cmd |=> !sys_cmd;
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command too long");
    c_write: cover property (ack && we);
    c_cmd: cover property (sys_cmd);
    c_pin: cover property ($fell(reset_pin_n));
    c_phy_busy: cover property (ack && !we && addr == ECR_IDX_PHY_CTL && rdata[15]);
endmodule : ecr_assertions

// ==== ecr_device.sv ====
// Device end: status, main control and PHY control registers
// Contract
// - Power-on loads every register default
// - Held low reset pin keeps system reset
// - Filter ignores pulses up to minimum width
// - Serial reset command performs full reset
// - Reset pin is never driven, input only
// - Host waits fifty microseconds before PHY access
// - System reset defaults registers, keeps buffer
// - Transmit reset aborts and clears transmit request
// - Transmit reset touches transmit logic only
// - System reset includes transmit and receive resets
// - Host clears transmit reset to resume
// - Receive reset clears enable, aborts reception
// - Receive reset touches receive logic only
// - Host clears receive reset to resume
// - PHY reset bit defaults all PHY registers
// - PHY reset self-clears after internal delay
// - Host polls PHY reset before use
// - Loopback returns data, disables twisted pair
// - Power-down bit shuts the PHY down
// - Duplex bit selects mode, defaults from strap
// - Clock ready cleared only by power-on
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module ecr_device
    import ecr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    ecr_if.device lnk,
    input wire logic second_led_pin,
    input wire logic tx_done,
    input wire logic rx_active,
    output logic tx_logic_rst,
    output logic rx_logic_rst,
    output logic tx_abort,
    output logic rx_abort,
    output logic transmit_request,
    output logic receive_enable,
    output logic phy_in_reset,
    output logic phy_loopback,
    output logic phy_power_down,
    output logic phy_full_duplex,
    output logic tp_enable,
    output logic clock_ready_flag,
    output logic system_reset_active
);
    typedef struct packed {
        logic transmit_logic_reset;
        logic receive_logic_reset;
        logic tx_req;
        logic rx_en;
        logic phy_soft_reset;
        logic loopback;
        logic power_down;
        logic duplex;
        logic [7:0] phy_cnt;
        logic [7:0] ost_cnt;
        logic clk_rdy;
        logic strap_taken;
        logic strap;
        logic [7:0] cmd_cnt;
        logic ack;
        logic [15:0] rdata;
        logic tx_abort;
        logic rx_abort;
        logic tx_lrst;
        logic rx_lrst;
        logic sysr;
        logic tp_en;
    } ecr_dev_s;

    ecr_dev_s st_r;
    ecr_dev_s st_nxt;
    logic pin_low;
    logic sys;

    ecr_pin_filter #(
        .CYC(ECR_MIN_PULSE_CYC)
    ) u_filter (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_n(lnk.reset_pin_n),
        .held_low(pin_low)
    );

    // Pin or serial command holds system reset
    assign sys = pin_low | (st_r.cmd_cnt != 8'h00);

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.tx_abort = 1'b0;
        st_nxt.rx_abort = 1'b0;
        // Serial command starts a timed system reset
        if (st_r.cmd_cnt != 8'h00) begin
            st_nxt.cmd_cnt = st_r.cmd_cnt - 8'h01;
        end
        if (lnk.sys_cmd) begin
            st_nxt.cmd_cnt = 8'(ECR_SYS_CMD_CYC);
        end
        // Oscillator timer sets clock ready once
        if (!st_r.clk_rdy) begin
            st_nxt.ost_cnt = st_r.ost_cnt + 8'h01;
            if (st_r.ost_cnt == 8'(ECR_OST_CYC - 1)) begin
                st_nxt.clk_rdy = 1'b1;
            end
        end
        // Strap caught in first cycle after release
        if (!st_r.strap_taken) begin
            st_nxt.strap_taken = 1'b1;
            st_nxt.strap = second_led_pin;
            st_nxt.duplex = second_led_pin;
        end
        // Delay then hardware clears PHY reset
        if (st_r.phy_soft_reset) begin
            st_nxt.phy_cnt = st_r.phy_cnt - 8'h01;
            if (st_r.phy_cnt == 8'h01) begin
                st_nxt.phy_soft_reset = 1'b0;
            end
        end
        // Transmission end clears the request
        if (tx_done) begin
            st_nxt.tx_req = 1'b0;
        end
        // Register access, one-cycle acknowledge
        if (lnk.req && !st_r.ack) begin
            st_nxt.ack = 1'b1;
            st_nxt.rdata = 16'h0000;
            unique case (lnk.addr)
                ECR_IDX_MAIN_CTL: begin
                    st_nxt.rdata[ECR_MC_TX_RST] = st_r.transmit_logic_reset;
                    st_nxt.rdata[ECR_MC_RX_RST] = st_r.receive_logic_reset;
                    st_nxt.rdata[ECR_MC_TX_REQ] = st_r.tx_req;
                    st_nxt.rdata[ECR_MC_RX_EN] = st_r.rx_en;
                end
                ECR_IDX_PHY_CTL: begin
                    st_nxt.rdata[ECR_PC_SOFT_RST] = st_r.phy_soft_reset;
                    st_nxt.rdata[ECR_PC_LOOPBACK] = st_r.loopback;
                    st_nxt.rdata[ECR_PC_POWER_DOWN] = st_r.power_down;
                    st_nxt.rdata[ECR_PC_DUPLEX] = st_r.duplex;
                end
                ECR_IDX_STATUS: begin
                    st_nxt.rdata[ECR_ST_CLK_RDY] = st_r.clk_rdy;
                end
                default: begin
                    st_nxt.rdata = 16'h0000;
                end
            endcase
            if (lnk.we && lnk.addr == ECR_IDX_MAIN_CTL) begin
                st_nxt.transmit_logic_reset = lnk.wdata[ECR_MC_TX_RST];
                st_nxt.receive_logic_reset = lnk.wdata[ECR_MC_RX_RST];
                st_nxt.tx_req = lnk.wdata[ECR_MC_TX_REQ];
                st_nxt.rx_en = lnk.wdata[ECR_MC_RX_EN];
                // Transmit reset aborts and drops request
                if (lnk.wdata[ECR_MC_TX_RST]) begin
                    st_nxt.tx_req = 1'b0;
                    st_nxt.tx_abort = st_r.tx_req;
                end
                // Receive reset drops enable, aborts packet
                if (lnk.wdata[ECR_MC_RX_RST]) begin
                    st_nxt.rx_en = 1'b0;
                    st_nxt.rx_abort = rx_active;
                end
            end
            if (lnk.we && lnk.addr == ECR_IDX_PHY_CTL) begin
                st_nxt.loopback = lnk.wdata[ECR_PC_LOOPBACK];
                st_nxt.power_down = lnk.wdata[ECR_PC_POWER_DOWN];
                st_nxt.duplex = lnk.wdata[ECR_PC_DUPLEX];
                if (lnk.wdata[ECR_PC_SOFT_RST]) begin
                    st_nxt.phy_soft_reset = 1'b1;
                    st_nxt.phy_cnt = 8'(ECR_PHY_RST_CYC);
                    st_nxt.loopback = ECR_RST_PHY_BIT;
                    st_nxt.power_down = ECR_RST_PHY_BIT;
                    st_nxt.duplex = st_r.strap;
                end
            end
        end
        // While transmit reset is held no request can start
        if (st_nxt.transmit_logic_reset) begin
            st_nxt.tx_req = 1'b0;
        end
        // While receive reset is held reception stays off
        if (st_nxt.receive_logic_reset) begin
            st_nxt.rx_en = 1'b0;
        end
        // System reset defaults registers, clock ready kept
        if (sys) begin
            st_nxt.tx_abort = st_r.tx_req;
            st_nxt.rx_abort = rx_active;
            st_nxt.transmit_logic_reset = ECR_RST_CTL_BIT;
            st_nxt.receive_logic_reset = ECR_RST_CTL_BIT;
            st_nxt.tx_req = ECR_RST_CTL_BIT;
            st_nxt.rx_en = ECR_RST_CTL_BIT;
            st_nxt.phy_soft_reset = ECR_RST_PHY_BIT;
            st_nxt.phy_cnt = 8'h00;
            st_nxt.loopback = ECR_RST_PHY_BIT;
            st_nxt.power_down = ECR_RST_PHY_BIT;
            st_nxt.duplex = st_r.strap_taken ? st_r.strap : second_led_pin;
        end
        // System reset drives both logic resets
        // Transmit reset reaches transmit logic only
        st_nxt.tx_lrst = st_nxt.transmit_logic_reset | sys;
        // Receive reset reaches receive logic only
        st_nxt.rx_lrst = st_nxt.receive_logic_reset | sys;
        st_nxt.sysr = sys;
        // Loopback or power-down disables twisted pair
        st_nxt.tp_en = !(st_nxt.loopback | st_nxt.power_down | st_nxt.phy_soft_reset);
    end

    // Power-on clears all state to defaults
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign lnk.ack = st_r.ack;
    assign lnk.rdata = st_r.rdata;
    assign tx_logic_rst = st_r.tx_lrst;
    assign rx_logic_rst = st_r.rx_lrst;
    assign tx_abort = st_r.tx_abort;
    assign rx_abort = st_r.rx_abort;
    assign transmit_request = st_r.tx_req;
    assign receive_enable = st_r.rx_en;
    assign phy_in_reset = st_r.phy_soft_reset;
    assign phy_loopback = st_r.loopback;
    assign phy_power_down = st_r.power_down;
    assign phy_full_duplex = st_r.duplex;
    assign tp_enable = st_r.tp_en;
    assign clock_ready_flag = st_r.clk_rdy;
    assign system_reset_active = st_r.sysr;
endmodule : ecr_device

// ==== ecr_host.sv ====
// Host end: Wishbone-driven sequencer for the device reset controls
`timescale 1ns/1ps
module ecr_host
    import ecr_pkg::*;
#(
    parameter int PHY_WAIT_CYC = ECR_PHY_WAIT_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    ecr_if.host lnk,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b01,
        H_XFER = 2'b10
    } ecr_hst_e;

    typedef struct packed {
        ecr_hst_e fsm;
        logic busy;
        logic [1:0] op;
        logic [1:0] cadr;
        logic [15:0] cdat;
        logic [15:0] rdat;
        logic phy_busy;
        logic poll;
        logic [15:0] wait_cnt;
        logic pin_n;
        logic req;
        logic we;
        logic [1:0] addr;
        logic [15:0] wdata;
        logic sys_cmd;
        logic ack;
        logic [31:0] dat;
    } ecr_hst_s;

    ecr_hst_s h_r;
    ecr_hst_s h_nxt;
    logic phy_ok;

    // PHY usable once the reset wait and PHY reset are both over
    assign phy_ok = (h_r.wait_cnt == 16'h0000) && !h_r.phy_busy;

    // Next-state logic
    always_comb begin
        h_nxt = h_r;
        h_nxt.ack = 1'b0;
        h_nxt.sys_cmd = 1'b0;
        if (h_r.wait_cnt != 16'h0000) begin
            h_nxt.wait_cnt = h_r.wait_cnt - 16'h0001;
        end
        // Pin held low restarts the PHY wait
        if (!h_r.pin_n) begin
            h_nxt.wait_cnt = 16'(PHY_WAIT_CYC + ECR_MIN_PULSE_CYC);
        end
        // Wishbone slave, ack one cycle after strobe
        if (wb_cyc_i && wb_stb_i && !h_r.ack) begin
            h_nxt.ack = 1'b1;
            h_nxt.dat = 32'h0000_0000;
            if (wb_adr_i == ECR_H_STAT) begin
                h_nxt.dat = {h_r.rdat, 13'h0000, h_r.phy_busy, !phy_ok, h_r.busy};
            end else if (wb_adr_i == ECR_H_PIN) begin
                h_nxt.dat = {31'h0000_0000, h_r.pin_n};
            end
            if (wb_we_i && wb_adr_i == ECR_H_CMD && wb_sel_i[0] && !h_r.busy) begin
                h_nxt.busy = (wb_dat_i[1:0] != 2'h0);
                h_nxt.op = wb_dat_i[1:0];
                h_nxt.cadr = wb_dat_i[3:2];
                h_nxt.cdat = wb_dat_i[31:16];
            end
            if (wb_we_i && wb_adr_i == ECR_H_PIN && wb_sel_i[0]) begin
                h_nxt.pin_n = wb_dat_i[0];
            end
        end
        unique case (h_r.fsm)
            H_IDLE: begin
                if (h_r.busy && h_r.op == ECR_OP_SYSRST) begin
                    // Command reset also arms the PHY wait
                    h_nxt.sys_cmd = 1'b1;
                    h_nxt.wait_cnt = 16'(PHY_WAIT_CYC + ECR_SYS_CMD_CYC);
                    h_nxt.phy_busy = 1'b0;
                    h_nxt.busy = 1'b0;
                end else if (h_r.busy && (h_r.cadr != ECR_IDX_PHY_CTL || phy_ok)) begin
                    h_nxt.fsm = H_XFER;
                    h_nxt.req = 1'b1;
                    h_nxt.we = (h_r.op == ECR_OP_WRITE);
                    h_nxt.addr = h_r.cadr;
                    h_nxt.wdata = h_r.cdat;
                    h_nxt.poll = 1'b0;
                end else if (h_r.phy_busy && h_r.wait_cnt == 16'h0000) begin
                    // Poll PHY reset bit until it clears
                    h_nxt.fsm = H_XFER;
                    h_nxt.req = 1'b1;
                    h_nxt.we = 1'b0;
                    h_nxt.addr = ECR_IDX_PHY_CTL;
                    h_nxt.poll = 1'b1;
                end
            end
            H_XFER: begin
                if (lnk.ack) begin
                    h_nxt.fsm = H_IDLE;
                    h_nxt.req = 1'b0;
                    if (h_r.addr == ECR_IDX_PHY_CTL) begin
                        h_nxt.phy_busy = h_r.we ? h_r.wdata[ECR_PC_SOFT_RST]
                                                : lnk.rdata[ECR_PC_SOFT_RST];
                    end
                    if (!h_r.poll) begin
                        h_nxt.busy = 1'b0;
                        h_nxt.rdat = h_r.we ? h_r.rdat : lnk.rdata;
                    end
                end
            end
            default: begin
                h_nxt.fsm = H_IDLE;
            end
        endcase
    end

    // State register; reset pin released at power-on
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            h_r <= '0;
            h_r.fsm <= H_IDLE;
            h_r.pin_n <= 1'b1;
        end else begin
            h_r <= h_nxt;
        end
    end

    // Host alone drives the reset pin
    assign lnk.reset_pin_n = h_r.pin_n;
    assign lnk.req = h_r.req;
    assign lnk.we = h_r.we;
    assign lnk.addr = h_r.addr;
    assign lnk.wdata = h_r.wdata;
    assign lnk.sys_cmd = h_r.sys_cmd;
    assign wb_ack_o = h_r.ack;
    assign wb_dat_o = h_r.dat;
endmodule : ecr_host

// ==== ecr_if.sv ====
// Link between host controller end and device end
`timescale 1ns/1ps
interface ecr_if;
    logic req;
    logic we;
    logic [1:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ack;
    logic sys_cmd;
    logic reset_pin_n;
    modport device (
        input req,
        input we,
        input addr,
        input wdata,
        input sys_cmd,
        input reset_pin_n,
        output rdata,
        output ack
    );
    modport host (
        output req,
        output we,
        output addr,
        output wdata,
        output sys_cmd,
        output reset_pin_n,
        input rdata,
        input ack
    );
endinterface : ecr_if

// ==== ecr_pin_filter.sv ====
// Glitch filter for the active-low external reset pin
`timescale 1ns/1ps
module ecr_pin_filter #(
    parameter int CYC = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pin_n,
    output logic held_low
);
    typedef struct packed {
        logic [7:0] cnt;
        logic low;
    } ecr_flt_s;
    ecr_flt_s r_r;
    ecr_flt_s r_nxt;

    // Count low cycles; assert only after they exceed the pulse width
    always_comb begin
        r_nxt = r_r;
        if (pin_n) begin
            r_nxt.cnt = 8'h00;
            r_nxt.low = 1'b0;
        end else if (r_r.cnt >= 8'(CYC)) begin
            r_nxt.low = 1'b1;
        end else begin
            r_nxt.cnt = r_r.cnt + 8'h01;
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign held_low = r_r.low;
endmodule : ecr_pin_filter

// ==== ecr_pin_filter_dummy_placeholder.sv ====
// Intentionally empty companion file
`timescale 1ns/1ps

// ==== ecr_pkg.sv ====
// Shared constants and register layout for the controller reset unit
package ecr_pkg;
    // Clock period in nanoseconds
    localparam int ECR_CLK_NS = 10;
    // Register indices on the device link
    localparam logic [1:0] ECR_IDX_MAIN_CTL = 2'h0;
    localparam logic [1:0] ECR_IDX_PHY_CTL = 2'h1;
    localparam logic [1:0] ECR_IDX_STATUS = 2'h2;
    // Main control field positions
    localparam int ECR_MC_TX_RST = 7;
    localparam int ECR_MC_RX_RST = 6;
    localparam int ECR_MC_TX_REQ = 3;
    localparam int ECR_MC_RX_EN = 2;
    // PHY control field positions
    localparam int ECR_PC_SOFT_RST = 15;
    localparam int ECR_PC_LOOPBACK = 14;
    localparam int ECR_PC_POWER_DOWN = 11;
    localparam int ECR_PC_DUPLEX = 8;
    // Status field positions
    localparam int ECR_ST_CLK_RDY = 0;
    // Reset values
    localparam logic ECR_RST_CTL_BIT = 1'b0;
    localparam logic ECR_RST_PHY_BIT = 1'b0;
    // Timing in nanoseconds (PHY wait in microseconds) and derived cycle counts
    localparam int ECR_MIN_PULSE_NS = 400;
    localparam int ECR_MIN_PULSE_CYC = (ECR_MIN_PULSE_NS + ECR_CLK_NS - 1) / ECR_CLK_NS;
    localparam int ECR_PHY_RST_NS = 1000;
    localparam int ECR_PHY_RST_CYC = ECR_PHY_RST_NS / ECR_CLK_NS;
    localparam int ECR_OST_NS = 1000;
    localparam int ECR_OST_CYC = ECR_OST_NS / ECR_CLK_NS;
    localparam int ECR_SYS_CMD_NS = 80;
    localparam int ECR_SYS_CMD_CYC = ECR_SYS_CMD_NS / ECR_CLK_NS;
    localparam int ECR_PHY_WAIT_US = 50;
    localparam int ECR_PHY_WAIT_CYC = (ECR_PHY_WAIT_US * 1000 + ECR_CLK_NS - 1) / ECR_CLK_NS;
    // Host register byte offsets
    localparam logic [3:0] ECR_H_CMD = 4'h0;
    localparam logic [3:0] ECR_H_STAT = 4'h4;
    localparam logic [3:0] ECR_H_PIN = 4'h8;
    // Host command codes
    localparam logic [1:0] ECR_OP_WRITE = 2'h1;
    localparam logic [1:0] ECR_OP_READ = 2'h2;
    localparam logic [1:0] ECR_OP_SYSRST = 2'h3;
endpackage : ecr_pkg

// ==== tb_top.sv ====
// Bench joining host and device ends over the link
`timescale 1ns/1ps
module tb_top
    import ecr_pkg::*;
;
    localparam int WAIT_CYC = 50;
    logic ref_clk, rst, cyc, stb, we, strap, tx_done, rx_active;
    logic [3:0] adr;
    logic [31:0] wdat, rdat, dat_o;
    logic ack_o, tx_lr, rx_lr, tx_ab, rx_ab, treq, ren, phy_rst, lpbk, pdn, fdx, tpe, crdy, sra;
    logic s_txa, s_rxa, s_sra, s_both, s_pin;
    logic [15:0] d;
    int fail_count, compares, n;
    ecr_if lnk();
    ecr_host #(.PHY_WAIT_CYC(WAIT_CYC)) ecr_host_inst (.ref_clk(ref_clk), .rst(rst), .lnk(lnk),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack_o));
    ecr_device ecr_device_inst (.ref_clk(ref_clk), .rst(rst), .lnk(lnk), .second_led_pin(strap),
        .tx_done(tx_done), .rx_active(rx_active), .tx_logic_rst(tx_lr), .rx_logic_rst(rx_lr),
        .tx_abort(tx_ab), .rx_abort(rx_ab), .transmit_request(treq), .receive_enable(ren),
        .phy_in_reset(phy_rst), .phy_loopback(lpbk), .phy_power_down(pdn),
        .phy_full_duplex(fdx), .tp_enable(tpe), .clock_ready_flag(crdy),
        .system_reset_active(sra));
    ecr_assertions #(.PHY_WAIT_CYC(WAIT_CYC)) ecr_assertions_inst (.ref_clk(ref_clk), .rst(rst),
        .req(lnk.req), .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata),
        .ack(lnk.ack), .sys_cmd(lnk.sys_cmd), .reset_pin_n(lnk.reset_pin_n));
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Sticky records of short events
    always @(posedge ref_clk) begin
        if (tx_ab === 1'b1) s_txa <= 1'b1;
        if (rx_ab === 1'b1) s_rxa <= 1'b1;
        if (sra === 1'b1) s_sra <= 1'b1;
        if (sra === 1'b1 && tx_lr === 1'b1 && rx_lr === 1'b1) s_both <= 1'b1;
        if (lnk.reset_pin_n !== 1'b1) s_pin <= 1'b1;
    end
    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // One classic Wishbone cycle
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] dt);
        int k;
        k = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= dt;
        do begin
            @(posedge ref_clk);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (k >= 50) check("wb ack", 1, 0);
    endtask : wb
    task automatic wait_idle();
        int k;
        k = 0;
        do begin
            wb(1'b0, ECR_H_STAT, 32'h0);
            k++;
        end while (rdat[0] !== 1'b0 && k < 5000);
        if (k >= 5000) check("busy", 0, 1);
    endtask : wait_idle
    task automatic dev_wr(input logic [1:0] i, input logic [15:0] v);
        wb(1'b1, ECR_H_CMD, {v, 12'h0, i, ECR_OP_WRITE});
        wait_idle();
    endtask : dev_wr
    task automatic dev_rd(input logic [1:0] i, output logic [15:0] v);
        wb(1'b1, ECR_H_CMD, {16'h0, 12'h0, i, ECR_OP_READ});
        wait_idle();
        v = rdat[31:16];
    endtask : dev_rd
    task automatic clr();
        @(negedge ref_clk);
        {s_txa, s_rxa, s_sra, s_both, s_pin} = 5'h0;
    endtask : clr
    // Watchdog
    initial begin
        #500000;
        fail_count++;
        complete_run();
    end
    // Test sequence
    initial begin
        {rst, cyc, stb, we, adr, wdat, strap, tx_done, rx_active} = {4'h8, 4'h0, 32'h0, 3'h4};
        {s_txa, s_rxa, s_sra, s_both, s_pin} = 5'h0;
        fail_count = 0;
        compares = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        // Power-on defaults
        @(posedge ref_clk);
        check("ready early", 0, crdy);
        wb(1'b0, ECR_H_PIN, 32'h0);
        check("pin reg", 1, rdat[0]);
        wb(1'b0, 4'hc, 32'h0);
        check("unmapped", 0, rdat);
        dev_rd(ECR_IDX_MAIN_CTL, d);
        check("main default", 0, d);
        dev_rd(ECR_IDX_PHY_CTL, d);
        check("phy default", 16'h0100, d);
        dev_rd(2'h3, d);
        check("index 3", 0, d);
        repeat (ECR_OST_CYC) @(posedge ref_clk);
        dev_rd(ECR_IDX_STATUS, d);
        check("ready", 1, d[ECR_ST_CLK_RDY]);
        // Transmit-only reset
        dev_wr(ECR_IDX_MAIN_CTL, 16'h000c);
        rx_active <= 1'b1;
        clr();
        dev_wr(ECR_IDX_MAIN_CTL, 16'h0084);
        check("tx req", 0, treq);
        check("tx abort", 1, s_txa);
        check("tx rst", 1, tx_lr);
        check("rx kept", 1, ren);
        check("no rx abort", 0, s_rxa);
        dev_wr(ECR_IDX_MAIN_CTL, 16'h0004);
        check("tx resumed", 0, tx_lr);
        // Receive-only reset
        dev_wr(ECR_IDX_MAIN_CTL, 16'h000c);
        clr();
        dev_wr(ECR_IDX_MAIN_CTL, 16'h004c);
        check("rx en", 0, ren);
        check("rx abort", 1, s_rxa);
        check("rx rst", 1, rx_lr);
        check("tx kept", 1, treq);
        check("no tx abort", 0, s_txa);
        dev_wr(ECR_IDX_MAIN_CTL, 16'h0008);
        check("rx resumed", 0, rx_lr);
        rx_active <= 1'b0;
        tx_done <= 1'b1;
        @(posedge ref_clk);
        tx_done <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("tx done", 0, treq);
        // PHY control bits, reserved bits written high
        dev_wr(ECR_IDX_PHY_CTL, 16'h4aff);
        dev_rd(ECR_IDX_PHY_CTL, d);
        check("phy reserved", 16'h4800, d);
        check("loopback", 1, lpbk);
        check("tp off", 0, tpe);
        check("power down", 1, pdn);
        check("half duplex", 0, fdx);
        dev_wr(ECR_IDX_PHY_CTL, 16'h0100);
        check("tp on", 1, tpe);
        check("full duplex", 1, fdx);
        // PHY soft reset and its delay
        dev_wr(ECR_IDX_PHY_CTL, 16'h4800);
        wb(1'b1, ECR_H_CMD, {16'h8000, 12'h0, ECR_IDX_PHY_CTL, ECR_OP_WRITE});
        n = 0;
        while (phy_rst !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        n = 0;
        while (phy_rst === 1'b1 && n < 1000) begin
            @(posedge ref_clk);
            n++;
        end
        check("phy rst hold", ECR_PHY_RST_CYC, n);
        wait_idle();
        dev_rd(ECR_IDX_PHY_CTL, d);
        check("phy after rst", 16'h0100, d);
        // System reset by command
        dev_wr(ECR_IDX_MAIN_CTL, 16'h000c);
        dev_wr(ECR_IDX_PHY_CTL, 16'h4800);
        clr();
        wb(1'b1, ECR_H_CMD, {30'h0, ECR_OP_SYSRST});
        repeat (ECR_SYS_CMD_CYC + 4) @(posedge ref_clk);
        check("sys rst", 1, s_sra);
        check("both resets", 1, s_both);
        check("sys rst end", 0, sra);
        check("pin undriven", 0, s_pin);
        wait_idle();
        check("ready kept", 1, crdy);
        dev_rd(ECR_IDX_MAIN_CTL, d);
        check("main after sys", 0, d);
        dev_rd(ECR_IDX_PHY_CTL, d);
        check("phy after sys", 16'h0100, d);
        // Pin glitch then held low
        dev_wr(ECR_IDX_MAIN_CTL, 16'h0004);
        clr();
        wb(1'b1, ECR_H_PIN, 32'h0);
        repeat (ECR_MIN_PULSE_CYC - 6) @(posedge ref_clk);
        wb(1'b1, ECR_H_PIN, 32'h1);
        repeat (4) @(posedge ref_clk);
        check("glitch", 0, s_sra);
        check("glitch rx en", 1, ren);
        wb(1'b1, ECR_H_PIN, 32'h0);
        repeat (ECR_MIN_PULSE_CYC + 10) @(posedge ref_clk);
        check("pin rst", 1, sra);
        check("ready pin", 1, crdy);
        wb(1'b1, ECR_H_PIN, 32'h1);
        repeat (ECR_MIN_PULSE_CYC + 10) @(posedge ref_clk);
        check("pin rst end", 0, sra);
        dev_rd(ECR_IDX_MAIN_CTL, d);
        check("main after pin", 0, d);
        complete_run();
    end
endmodule : tb_top
